/* File: include/supply_low_detect_params.svh */
// Constants of the supply under-voltage detector control block.
// Assumes inclusion by its bare name from the package and the control block RTL file.
`ifndef SUPPLY_LOW_DETECT_PARAMS_SVH
`define SUPPLY_LOW_DETECT_PARAMS_SVH

// APB byte addresses
`define SLD_ADDR_CONTROL    12'h000
`define SLD_ADDR_IRQ_STATUS 12'h004
`define SLD_ADDR_IRQ_ENABLE 12'h008
`define SLD_ADDR_IRQ_CLEAR  12'h00C
`define SLD_ADDR_CORE_CTRL  12'h010

// Control register fields
`define SLD_TRIP_LSB        0
`define SLD_TRIP_MSB        3
`define SLD_ENABLE_BIT      4
`define SLD_STABLE_BIT      5
`define SLD_TRIP_RESET      4'h5
`define SLD_TRIP_EXTERNAL   4'hF

// Interrupt status bits
`define SLD_IRQ_UV_BIT      0
`define SLD_IRQ_STABLE_BIT  1
`define SLD_IRQ_WIDTH       2

// Core control bits
`define SLD_CORE_GIE_BIT    0
`define SLD_CORE_SLEEP_BIT  1

// Reference settle time in ns and clock period in ns
`define SLD_SETTLE_NS       20000
`define SLD_CLK_NS          25
`define SLD_SETTLE_CYCLES   ((`SLD_SETTLE_NS + `SLD_CLK_NS - 1) / `SLD_CLK_NS)

`endif

/* File: include/supply_low_detect_pkg.sv */
// Types shared by the supply under-voltage detector control block.
// Assumes the params header is on the include path.
`include "supply_low_detect_params.svh"

package supply_low_detect_pkg;
    typedef logic [3:0] trip_t;
    typedef enum logic [1:0] {
        REF_OFF,
        REF_SETTLING,
        REF_STABLE
    } ref_state_e;
endpackage

/* File: rtl/sld_sync3.sv */
// Three-stage synchroniser with agreement filter for one pin input.
// Assumes the input is asynchronous to clk.
`timescale 1ns/1ps

module sld_sync3 #(
    parameter logic RESET_VAL = 1'b0
) (
    // Clock and reset
    input  wire  logic clk,
    input  wire  logic rst_n,
    // Data
    input  wire  logic async_in,
    output logic       sync_out
);
    logic [2:0] stage_r;

    // Shift chain; only stage 1 and 2 are looked at
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            stage_r <= {3{RESET_VAL}};
        end else begin
            stage_r <= {stage_r[1:0], async_in};
        end
    end

    // A change counts once the second and third stages agree
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sync_out <= RESET_VAL;
        end else if (stage_r[1] == stage_r[2]) begin
            sync_out <= stage_r[2];
        end
    end
endmodule // sld_sync3

/* File: rtl/sld_settle_timer.sv */
// Reference settle timer: counts a fixed time measured in ns.
// Assumes clk runs at the nominal rate the count was derived from.
`timescale 1ns/1ps

module sld_settle_timer #(
    parameter int CYCLES = 800
) (
    // Clock and reset
    input  wire  logic clk,
    input  wire  logic rst_n,
    // Control
    input  wire  logic start,
    input  wire  logic run,
    output logic       done
);
    localparam int CW = $clog2(CYCLES + 1);
    logic [CW-1:0] count_r;

    // Restarts on start, clears when run drops, saturates at CYCLES
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            count_r <= '0;
        end else if (!run || start) begin
            count_r <= '0;
        end else if (count_r != CW'(CYCLES)) begin
            count_r <= count_r + CW'(1);
        end
    end

    assign done = run && !start && (count_r == CW'(CYCLES));
endmodule // sld_settle_timer

/* File: rtl/supply_low_detect_ctrl.sv */
// Control and flag logic of the programmable supply under-voltage detector.
// Assumes an APB master on pclk, an analog comparator and tap mux outside,
// and a core that sleeps and takes a vectored interrupt.
//
// Added by the designer: the register addresses and register access over APB.
`timescale 1ns/1ps
`include "supply_low_detect_params.svh"

////////////////////////////////////////////////////////////////////////////////
// Summary of operation
// [R1] Falling supply below trip sets under-voltage flag
// [R2] Enabled flag raises interrupt toward the vector
// [R3] Four-bit trip field in control bits 3:0
// [R4] Code 1111 selects the external sense pin
// [R5] Codes 0000 to 1110 pick rising divider taps
// [R6] Bit 4 powers detector and enables detection
// [R7] Bit 5 reads 1 once reference stable
// [R8] Control bits 7:6 read zero
// [R9] Reset: enable off, flag off, trip 0101
// [R10] Software: select, mask, enable, wait, clear, unmask
// [R11] No flagging before reference becomes stable
// [R12] Settle time is fixed time, not clock-scaled
// [R13] Detector keeps working in sleep and wakes
// [R14] Wake vectors only with global interrupts enabled
// [R15] Shared reference needs start-up when all unused
// [R16] Software enables detector only for short checks
// [R17] Flag stays set until software clears it
module supply_low_detect_ctrl
    import supply_low_detect_pkg::*;
#(
    parameter int SETTLE_CYCLES = `SLD_SETTLE_CYCLES
) (
    // APB slave
    input  wire  logic        pclk,
    input  wire  logic        presetn,
    input  wire  logic        psel,
    input  wire  logic        penable,
    input  wire  logic        pwrite,
    input  wire  logic [11:0] paddr,
    input  wire  logic [31:0] pwdata,
    output logic       [31:0] prdata,
    output logic              pready,
    output logic              pslverr,
    // Analog side
    input  wire  logic        comparator_low,
    input  wire  logic        brownout_ref_on,
    output logic              monitor_power_enable,
    output logic       [3:0]  trip_level_select,
    output logic              external_sense_input_sel,
    output logic       [14:0] divider_tap_select,
    output logic              reference_on,
    // Core side
    input  wire  logic        core_sleeping,
    output logic              irq,
    output logic              vector_request,
    output logic              wake_request
);

    ////////////////////////////////////////////////////////////////////////////
    // Registers and wires
    logic                     enable_r;
    trip_t                    trip_r;
    logic [`SLD_IRQ_WIDTH-1:0] status_r;
    logic [`SLD_IRQ_WIDTH-1:0] irq_en_r;
    logic                     gie_r;
    ref_state_e               ref_state_r;
    logic                     stable_r;
    logic                     cmp_low_s;
    logic                     bor_ref_s;
    logic                     settle_start;
    logic                     settle_done;
    logic                     wr_en;
    logic                     rd_en;
    logic                     addr_hit;
    logic [`SLD_IRQ_WIDTH-1:0] clr_mask;
    logic [`SLD_IRQ_WIDTH-1:0] set_mask;
    logic                     stable_rise;
    logic                     uv_event;
    logic [31:0]              rdata_nxt;

    ////////////////////////////////////////////////////////////////////////////
    // Pin synchronisers: comparator and brown-out reference state are analog
    sld_sync3 #(.RESET_VAL(1'b0)) u_sync_cmp (
        .clk      (pclk),
        .rst_n    (presetn),
        .async_in (comparator_low),
        .sync_out (cmp_low_s)
    );

    sld_sync3 #(.RESET_VAL(1'b0)) u_sync_bor (
        .clk      (pclk),
        .rst_n    (presetn),
        .async_in (brownout_ref_on),
        .sync_out (bor_ref_s)
    );

    ////////////////////////////////////////////////////////////////////////////
    // APB decode: zero wait states, unmapped addresses answer with pslverr
    assign wr_en   = psel && penable && pwrite;
    assign rd_en   = psel && penable && !pwrite;
    assign pready  = 1'b1;
    assign addr_hit = (paddr == `SLD_ADDR_CONTROL)    ||
                      (paddr == `SLD_ADDR_IRQ_STATUS) ||
                      (paddr == `SLD_ADDR_IRQ_ENABLE) ||
                      (paddr == `SLD_ADDR_IRQ_CLEAR)  ||
                      (paddr == `SLD_ADDR_CORE_CTRL);
    assign pslverr = psel && penable && !addr_hit;

    ////////////////////////////////////////////////////////////////////////////
    // Control register: enable and trip level
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            enable_r <= 1'b0;                                     // [R9]
            trip_r   <= `SLD_TRIP_RESET;                          // [R9]
        end else if (wr_en && paddr == `SLD_ADDR_CONTROL) begin
            enable_r <= pwdata[`SLD_ENABLE_BIT];                  // [R6]
            trip_r   <= pwdata[`SLD_TRIP_MSB:`SLD_TRIP_LSB];      // [R3]
        end
    end

    // Core control: global interrupt enable mirror
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            gie_r <= 1'b0;
        end else if (wr_en && paddr == `SLD_ADDR_CORE_CTRL) begin
            gie_r <= pwdata[`SLD_CORE_GIE_BIT];
        end
    end

    // Interrupt enable register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_en_r <= '0;
        end else if (wr_en && paddr == `SLD_ADDR_IRQ_ENABLE) begin
            irq_en_r <= pwdata[`SLD_IRQ_WIDTH-1:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Analog steering outputs
    assign monitor_power_enable     = enable_r;                   // [R6]
    assign trip_level_select        = trip_r;                     // [R3]
    assign external_sense_input_sel = enable_r && (trip_r == `SLD_TRIP_EXTERNAL); // [R4]

    // One-hot divider tap, rising threshold with code; none for the pin
    always_comb begin
        divider_tap_select = '0;
        if (enable_r && trip_r != `SLD_TRIP_EXTERNAL) begin
            divider_tap_select[trip_r] = 1'b1;                    // [R5]
        end
    end

    // Reference is shared with brown-out; it runs while any user needs it
    assign reference_on = enable_r || bor_ref_s;                  // [R15]

    ////////////////////////////////////////////////////////////////////////////
    // Reference settle tracking: a fixed time, scaled from ns at build time
    // so a slower core clock would only lengthen it, never shorten below spec
    assign settle_start = (ref_state_r == REF_OFF) && reference_on;

    sld_settle_timer #(.CYCLES(SETTLE_CYCLES)) u_settle (
        .clk   (pclk),
        .rst_n (presetn),
        .start (settle_start),
        .run   (reference_on),
        .done  (settle_done)
    );                                                            // [R12]

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ref_state_r <= REF_OFF;
        end else begin
            unique case (ref_state_r)
                REF_OFF: begin
                    if (reference_on) begin
                        ref_state_r <= REF_SETTLING;              // [R15]
                    end
                end
                REF_SETTLING: begin
                    if (!reference_on) begin
                        ref_state_r <= REF_OFF;
                    end else if (settle_done) begin
                        ref_state_r <= REF_STABLE;
                    end
                end
                REF_STABLE: begin
                    if (!reference_on) begin
                        ref_state_r <= REF_OFF;
                    end
                end
            endcase
        end
    end

    // Stable flag only while this detector is enabled and reference settled
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            stable_r <= 1'b0;                                     // [R9]
        end else begin
            stable_r <= enable_r && (ref_state_r == REF_STABLE);  // [R7]
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Interrupt events; the comparator is ignored until the reference settles
    assign uv_event    = stable_r && cmp_low_s;                   // [R1] [R11]
    assign stable_rise = enable_r && (ref_state_r == REF_STABLE) && !stable_r;

    always_comb begin
        set_mask = '0;
        set_mask[`SLD_IRQ_UV_BIT]     = uv_event;
        set_mask[`SLD_IRQ_STABLE_BIT] = stable_rise;
    end

    assign clr_mask = (wr_en && paddr == `SLD_ADDR_IRQ_CLEAR) ?
                      pwdata[`SLD_IRQ_WIDTH-1:0] : '0;

    // Sticky status; a set in the clearing cycle wins
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            status_r <= '0;
        end else begin
            status_r <= (status_r & ~clr_mask) | set_mask;        // [R17]
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Interrupt, vector and wake outputs
    assign irq = |(status_r & irq_en_r);                          // [R2]

    // Vector only when the core may take interrupts, awake or woken
    assign vector_request = irq && gie_r;                         // [R2] [R14]

    // Detection keeps working in sleep; an enabled flag wakes the core
    assign wake_request = core_sleeping && irq;                   // [R13]

    ////////////////////////////////////////////////////////////////////////////
    // Read mux; upper bits of the control byte read zero
    always_comb begin
        rdata_nxt = 32'h0000_0000;
        unique case (paddr)
            `SLD_ADDR_CONTROL: begin
                rdata_nxt[`SLD_TRIP_MSB:`SLD_TRIP_LSB] = trip_r;
                rdata_nxt[`SLD_ENABLE_BIT] = enable_r;
                rdata_nxt[`SLD_STABLE_BIT] = stable_r;            // [R7] [R8]
            end
            `SLD_ADDR_IRQ_STATUS: begin
                rdata_nxt[`SLD_IRQ_WIDTH-1:0] = status_r;
            end
            `SLD_ADDR_IRQ_ENABLE: begin
                rdata_nxt[`SLD_IRQ_WIDTH-1:0] = irq_en_r;
            end
            `SLD_ADDR_CORE_CTRL: begin
                rdata_nxt[`SLD_CORE_GIE_BIT]   = gie_r;
                rdata_nxt[`SLD_CORE_SLEEP_BIT] = core_sleeping;
            end
            default: begin
                rdata_nxt = 32'h0000_0000;
            end
        endcase
    end

    // Read data registered at setup so it is stable in the access phase
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
        end else if (psel && !penable && !pwrite) begin
            prdata <= rdata_nxt;
        end
    end

    // rd_en kept for readers of the decode; reads have no side effects
    logic unused_rd;
    assign unused_rd = rd_en;

endmodule // supply_low_detect_ctrl

/* File: tb/supply_low_detect_ctrl_asserts.sv */
// Port-level checker for the supply under-voltage detector control block.
// Assumes a single pclk domain with asynchronous active-low presetn.
`timescale 1ns/1ps

module supply_low_detect_ctrl_asserts #(
    parameter int SETTLE_CYCLES = 800
) (
    // Clock and reset
    input wire logic        pclk,
    input wire logic        presetn,
    // APB
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    // Analog and core side
    input wire logic        monitor_power_enable,
    input wire logic [3:0]  trip_level_select,
    input wire logic        external_sense_input_sel,
    input wire logic [14:0] divider_tap_select,
    input wire logic        reference_on,
    input wire logic        core_sleeping,
    input wire logic        irq,
    input wire logic        vector_request,
    input wire logic        wake_request
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    ////////////////////////////////////////////////////////////////////////
    // Register and tap decode
    a_ctrl_write_lands: assert property (psel && penable && pwrite && paddr == 12'h000
        |=> {monitor_power_enable, trip_level_select} == 5'($past(pwdata)))
        else $error("control write not applied");
    a_ext_sel_code: assert property (external_sense_input_sel
        == (monitor_power_enable && trip_level_select == 4'hF))
        else $error("external sense select wrong");
    a_tap_one_hot: assert property (monitor_power_enable && trip_level_select != 4'hF
        |-> divider_tap_select == 15'(16'h0001 << trip_level_select))
        else $error("divider tap select wrong");
    a_off_no_tap: assert property (!monitor_power_enable
        |-> divider_tap_select == 15'h0000 && !external_sense_input_sel)
        else $error("tap selected while detector off");
    a_ref_follows_en: assert property (monitor_power_enable |-> reference_on)
        else $error("reference off while detector enabled");
    // Read data is loaded at setup, so check one edge later
    a_ctrl_high_zero: assert property (psel && !penable && !pwrite && paddr == 12'h000
        |=> prdata[31:6] == 26'h0)
        else $error("control upper bits not zero");

    ////////////////////////////////////////////////////////////////////////
    // Interrupt, vector and wake
    a_vector_needs_irq: assert property (vector_request |-> irq)
        else $error("vector without interrupt");
    a_wake_in_sleep: assert property (wake_request == (core_sleeping && irq))
        else $error("wake request mismatch");

    c_ext_sel: cover property (external_sense_input_sel);
    c_irq_rise: cover property ($rose(irq));
    c_wake: cover property (wake_request && !vector_request);
endmodule // supply_low_detect_ctrl_asserts

bind supply_low_detect_ctrl supply_low_detect_ctrl_asserts #(
    .SETTLE_CYCLES(SETTLE_CYCLES)
) i_asserts (.*);

/* File: tb/supply_low_detect_ctrl_tb.sv */
// Self-checking bench for the supply under-voltage detector control block.
// Assumes the design's zero-wait APB slave and a shortened settle count.
`timescale 1ns/1ps

module supply_low_detect_ctrl_tb;
    logic        pclk = 1'b0;
    logic        presetn = 1'b0;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic        comparator_low = 1'b0;
    logic        brownout_ref_on = 1'b0;
    logic        core_sleeping = 1'b0;
    logic [31:0] prdata, rd;
    logic        pready, pslverr, err_seen, monitor_power_enable;
    logic        external_sense_input_sel, reference_on, irq, vector_request, wake_request;
    logic [3:0]  trip_level_select;
    logic [14:0] divider_tap_select;
    int          miscompares = 0;
    int          n_tests = 0;
    int          cycles = 0;
    int          n;

    supply_low_detect_ctrl #(.SETTLE_CYCLES(5)) i_dut (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .comparator_low(comparator_low),
        .brownout_ref_on(brownout_ref_on), .monitor_power_enable(monitor_power_enable),
        .trip_level_select(trip_level_select),
        .external_sense_input_sel(external_sense_input_sel),
        .divider_tap_select(divider_tap_select), .reference_on(reference_on),
        .core_sleeping(core_sleeping), .irq(irq), .vector_request(vector_request),
        .wake_request(wake_request));

    ////////////////////////////////////////////////////////////////////////
    // Clock and hang guard; the run needs well under 2000 cycles
    always #12.5 pclk = ~pclk;
    always @(posedge pclk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            miscompares++;
            tally_and_finish();
        end
    end

    task automatic tally_and_finish();
        $display("Checks %0d, mismatches %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_tests++;
        if (got !== exp) begin
            miscompares++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask

    // One APB transfer; the 1 ns step lets the completing edge settle
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        int k;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        k = 0;
        do begin
            @(posedge pclk);
            k++;
        end while (pready !== 1'b1 && k < 50);
        rd = prdata;
        err_seen = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        #1;
    endtask

    function automatic logic [14:0] exp_tap(input logic en, input logic [3:0] t);
        return (en && t != 4'hF) ? 15'(16'h0001 << t) : 15'h0000;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        void'($urandom(15139));
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, 12'h000, 32'h0);
        check("ctrl reset", 32'h5, rd);
        $display("TEST reset done");
        // Every trip code, with random junk in read-only and unused bits
        for (int c = 0; c < 16; c++) begin
            apb(1'b1, 12'h000, ($urandom() & 32'hFFFF_FFE0) | 32'h10 | c);
            check("trip", c, {28'h0, trip_level_select});
            check("ext sel", (c == 15), {31'h0, external_sense_input_sel});
            check("taps", {17'h0, exp_tap(1'b1, c)}, {17'h0, divider_tap_select});
            apb(1'b0, 12'h000, 32'h0);
            check("ctrl rd", 32'h10 | c, rd & 32'hFFFF_FFDF);
        end
        $display("TEST trip codes done");
        // Power down, then re-enable and watch the reference settle
        apb(1'b1, 12'h000, 32'h5);
        check("ref off", 32'h0, {31'h0, reference_on});
        check("taps off", 32'h0, {17'h0, divider_tap_select});
        apb(1'b1, 12'h000, 32'h15);
        @(posedge pclk) comparator_low <= 1'b1;
        apb(1'b0, 12'h000, 32'h0);
        check("stable early", 32'h0, rd & 32'h20);
        apb(1'b0, 12'h004, 32'h0);
        check("no early flag", 32'h0, rd & 32'h1);
        @(posedge pclk) comparator_low <= 1'b0;
        n = 0;
        while (!rd[5] && n < 20) begin
            apb(1'b0, 12'h000, 32'h0);
            n++;
        end
        check("stable set", 32'h20, rd & 32'h20);
        repeat (8) @(posedge pclk);
        apb(1'b1, 12'h00C, 32'h3);
        apb(1'b0, 12'h004, 32'h0);
        check("status clear", 32'h0, rd);
        $display("TEST settle done");
        // Under-voltage pulse: sticky flag, vector, wake
        apb(1'b1, 12'h008, 32'h1);
        apb(1'b1, 12'h010, 32'h1);
        @(posedge pclk) comparator_low <= 1'b1;
        repeat (8) @(posedge pclk);
        comparator_low <= 1'b0;
        repeat (8) @(posedge pclk);
        apb(1'b0, 12'h004, 32'h0);
        check("uv flag", 32'h1, rd & 32'h1);
        check("irq vec", 32'h3, {30'h0, irq, vector_request});
        @(posedge pclk) core_sleeping <= 1'b1;
        apb(1'b1, 12'h010, 32'h0);
        check("wake no vec", 32'h2, {30'h0, wake_request, vector_request});
        apb(1'b1, 12'h00C, 32'h1);
        check("irq clear", 32'h0, {30'h0, irq, wake_request});
        core_sleeping <= 1'b0;
        $display("TEST under-voltage done");
        // Unmapped address is refused and leaves control alone
        apb(1'b1, 12'h020, 32'hFF);
        apb(1'b0, 12'h020, 32'h0);
        check("unmapped", 32'h1, {31'h0, err_seen});
        check("unmapped rd", 32'h0, rd);
        check("pready", 32'h1, {31'h0, pready});
        apb(1'b0, 12'h000, 32'h0);
        check("ctrl kept", 32'h15, rd & 32'h1F);
        // Reset in mid-run turns the detector off
        @(posedge pclk) presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, 12'h000, 32'h0);
        check("ctrl rst", 32'h5, rd);
        check("en rst", 32'h0, {31'h0, monitor_power_enable});
        $display("TEST reset again done");
        tally_and_finish();
    end
endmodule // supply_low_detect_ctrl_tb
